// ==== rtl/ifl_pkg.sv ====
// constants of the input fault latched status block
package ifl_pkg;
	// register width and access port width
	localparam int IFL_DATA_W = 8;
	localparam int IFL_ADDR_W = 8;
	localparam int IFL_NROWS = 5;
	// register offsets
	localparam logic [7:0] IFL_CH1_FAULT_ADDR = 8'h36;
	localparam logic [7:0] IFL_CH2_FAULT_ADDR = 8'h37;
	localparam logic [7:0] IFL_OVLD_MASK_ADDR = 8'h38;
	localparam logic [7:0] IFL_REG_SHORT_ADDR = 8'h39;
	localparam logic [7:0] IFL_OVHS_ADDR = 8'h3a;
	localparam logic [7:0] IFL_TVB_ADDR = 8'h3b;
	// rows of the latch bank
	localparam int IFL_ROW_CH1 = 0;
	localparam int IFL_ROW_CH2 = 1;
	localparam int IFL_ROW_REG = 2;
	localparam int IFL_ROW_OVHS = 3;
	localparam int IFL_ROW_TVB = 4;
	// channel fault field positions
	localparam int IFL_OPEN_BIT = 7;
	localparam int IFL_SHORTED_BIT = 6;
	localparam int IFL_POS_GND_BIT = 5;
	localparam int IFL_NEG_GND_BIT = 4;
	localparam int IFL_POS_BIAS_BIT = 3;
	localparam int IFL_NEG_BIAS_BIT = 2;
	localparam int IFL_POS_BATT_BIT = 1;
	localparam int IFL_NEG_BATT_BIT = 0;
	// overload mask field positions
	localparam int IFL_OVLD_CH1_MASK_BIT = 3;
	localparam int IFL_OVLD_CH2_MASK_BIT = 2;
	// regulator short field positions
	localparam int IFL_REG_MASK_BIT = 1;
	localparam int IFL_REG_FLAG_BIT = 0;
	// event latch field positions
	localparam int IFL_OV_CH1P_BIT = 7;
	localparam int IFL_OV_CH2N_BIT = 4;
	localparam int IFL_HS_INSERT_BIT = 3;
	localparam int IFL_HS_REMOVE_BIT = 2;
	localparam int IFL_HS_HOOK_BIT = 1;
	localparam int IFL_CAPACITY_BIT = 0;
	localparam int IFL_THR_UP_BIT = 7;
	localparam int IFL_THR_LOW_BIT = 6;
	localparam int IFL_VAD_UP_BIT = 5;
	localparam int IFL_VAD_DOWN_BIT = 4;
	localparam int IFL_BIAS_SC_BIT = 3;
	localparam int IFL_BIAS_OV_BIT = 0;
	// channel summary positions
	localparam int IFL_SUM_CH1_BIT = 7;
	localparam int IFL_SUM_CH2_BIT = 6;
	// reset value of every register
	localparam logic [7:0] IFL_RESET_VAL = 8'h00;
endpackage : ifl_pkg

// ==== rtl/ifl_latch_if.sv ====
// carrier between the register front end and the latch bank
`timescale 1ns/1ps
`default_nettype none
interface ifl_latch_if #(
	parameter int NROWS = 5,
	parameter int W = 8
);
	// raw conditions, one row per latched register
	logic [NROWS-1:0][W-1:0] raw;
	// read strobe of each row, clears it
	logic [NROWS-1:0] rd_clr;
	// latched state
	logic [NROWS-1:0][W-1:0] q;
	modport bank (input raw, input rd_clr, output q);
	modport user (output raw, output rd_clr, input q);
endinterface : ifl_latch_if
`default_nettype wire

// ==== rtl/ifl_latch_bank.sv ====
// bank of sticky flags, cleared by a read, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module ifl_latch_bank
	import ifl_pkg::*;
#(
	parameter int NROWS = 5,
	parameter int W = 8
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// raw, clear and state
	ifl_latch_if.bank lif
);
	////////////////////////////////////////////////////////////////
	// parameter check
	if (NROWS < 1 || W < 1)
	begin : g_bad
		$error("latch bank needs at least one row and one bit");
	end

	////////////////////////////////////////////////////////////////
	// next state: keep unless read, raw always sets
	logic [NROWS-1:0][W-1:0] q_next;
	always_comb
	begin
		for (int i = 0; i < NROWS; i++)
		begin
			q_next[i] = (lif.rd_clr[i] ? '0 : lif.q[i]) | lif.raw[i]; // R19
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			lif.q <= '0; // R16
		end
		else
		begin
			lif.q <= q_next;
		end
	end
endmodule : ifl_latch_bank
`default_nettype wire

// ==== rtl/ifl_status_top.sv ====
// latched input fault and event status registers with mask bits
// Notes on behaviour
// [R01] ch1 register 0x36: open bit7, shorted bit6
// [R02] ch1 bits 5,4: positive, negative short to ground
// [R03] ch1 bits 3,2: short to bias supply
// [R04] ch1 bits 1,0: short to battery line
// [R05] ch2 register 0x37: open bit7, shorted bit6
// [R06] ch2 ground 5,4; bias 3,2; battery 1,0
// [R07] 0x39: regulator short flag bit0, mask bit1
// [R08] 0x38: overload masks, bit3 ch1, bit2 ch2
// [R09] host writes zero to reserved; reads zero
// [R10] 0x3a bits 7..4: input overvoltage per pin
// [R11] 0x3a: insert bit3, remove bit2, hook bit1
// [R12] 0x3a bit0: processing capacity overload
// [R13] 0x3b: threshold up bit7, low bit6
// [R14] 0x3b: voice activity up bit5, down bit4
// [R15] 0x3b bits 3..0: bias short, high, low, overvoltage
// [R16] all registers reset to zero
// [R17] mask one blocks source from interrupt output
// [R18] channel summary bit7 ch1, bit6 ch2
// [R19] flag sticks until read, then re-sets if persisting
// [R20] writes to latched bits are ignored
`timescale 1ns/1ps
`default_nettype none
module ifl_status_top
	import ifl_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	// control register port
	input wire logic [IFL_ADDR_W-1:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [IFL_DATA_W-1:0] REG_WDATA_IN,
	output logic [IFL_DATA_W-1:0] REG_RDATA_OUT,
	output logic REG_RVALID_OUT,
	// raw conditions from the analogue detectors
	input wire logic [7:0] CH1_FAULT_IN,
	input wire logic [7:0] CH2_FAULT_IN,
	input wire logic REGULATOR_SHORT_IN,
	input wire logic [7:0] OVERVOLT_HEADSET_IN,
	input wire logic [7:0] THRESH_VOICE_BIAS_IN,
	input wire logic [1:0] CONVERTER_OVERLOAD_IN,
	// masks held in the other mask registers
	input wire logic [7:0] CH1_MASK_IN,
	input wire logic [7:0] CH2_MASK_IN,
	input wire logic [7:0] OVHS_MASK_IN,
	input wire logic [7:0] TVB_MASK_IN,
	// interrupt and summary
	output logic IRQ_OUT,
	output logic [7:0] CHANNEL_SUMMARY_OUT
);
	////////////////////////////////////////////////////////////////
	// address match helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		hit = (a == t);
	endfunction : hit

	////////////////////////////////////////////////////////////////
	// latch bank
	ifl_latch_if #(.NROWS(IFL_NROWS), .W(IFL_DATA_W)) lif ();

	ifl_latch_bank #(.NROWS(IFL_NROWS), .W(IFL_DATA_W)) u_bank (
		.clk(CLOCK_IN),
		.rst_b(RST_B_IN),
		.lif(lif.bank)
	);

	////////////////////////////////////////////////////////////////
	// raw conditions into the bank rows
	// channel 1 fault bits keep their register positions
	assign lif.raw[IFL_ROW_CH1] = CH1_FAULT_IN; // R01 R04
	// channel 2 uses the same layout, positive pin in the upper bit
	assign lif.raw[IFL_ROW_CH2] = CH2_FAULT_IN; // R05
	// regulator short sits alone in bit 0
	assign lif.raw[IFL_ROW_REG] = {7'h00, REGULATOR_SHORT_IN}; // R07
	// overvoltage, headset and capacity events
	assign lif.raw[IFL_ROW_OVHS] = OVERVOLT_HEADSET_IN; // R10
	// threshold, voice activity and bias events
	assign lif.raw[IFL_ROW_TVB] = THRESH_VOICE_BIAS_IN; // R13

	////////////////////////////////////////////////////////////////
	// address decode
	wire logic sel_ch1 = hit(REG_ADDR_IN, IFL_CH1_FAULT_ADDR); // channel 1 latch
	wire logic sel_ch2 = hit(REG_ADDR_IN, IFL_CH2_FAULT_ADDR); // channel 2 latch
	wire logic sel_ovld = hit(REG_ADDR_IN, IFL_OVLD_MASK_ADDR); // overload masks
	wire logic sel_reg = hit(REG_ADDR_IN, IFL_REG_SHORT_ADDR); // regulator
	wire logic sel_ovhs = hit(REG_ADDR_IN, IFL_OVHS_ADDR); // event latch one
	wire logic sel_tvb = hit(REG_ADDR_IN, IFL_TVB_ADDR); // event latch two

	// a read clears the latched bits of the addressed register
	assign lif.rd_clr[IFL_ROW_CH1] = REG_RD_IN && sel_ch1; // R19
	assign lif.rd_clr[IFL_ROW_CH2] = REG_RD_IN && sel_ch2; // R19
	assign lif.rd_clr[IFL_ROW_REG] = REG_RD_IN && sel_reg; // R19
	assign lif.rd_clr[IFL_ROW_OVHS] = REG_RD_IN && sel_ovhs; // R19
	assign lif.rd_clr[IFL_ROW_TVB] = REG_RD_IN && sel_tvb; // R19

	////////////////////////////////////////////////////////////////
	// writable mask bits
	logic ovld_ch1_mask_reg; // first converter overload mask bit
	logic ovld_ch2_mask_reg; // second converter overload mask bit
	logic reg_mask_reg; // regulator short mask bit
	wire logic wr_ovld = REG_WR_IN && sel_ovld; // overload mask write; R20
	wire logic wr_reg = REG_WR_IN && sel_reg; // regulator mask write

	// only mask fields take writes; latched and reserved bits ignore them
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			ovld_ch1_mask_reg <= 1'b0; // R16
			ovld_ch2_mask_reg <= 1'b0;
			reg_mask_reg <= 1'b0;
		end
		else
		begin
			if (wr_ovld)
			begin
				ovld_ch1_mask_reg <= REG_WDATA_IN[IFL_OVLD_CH1_MASK_BIT]; // R08
				ovld_ch2_mask_reg <= REG_WDATA_IN[IFL_OVLD_CH2_MASK_BIT]; // R08
			end
			if (wr_reg)
			begin
				reg_mask_reg <= REG_WDATA_IN[IFL_REG_MASK_BIT]; // R07
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// read data selection, reserved bits and unmapped reads are zero
	wire logic [7:0] ovld_view = {4'h0, ovld_ch1_mask_reg, ovld_ch2_mask_reg, 2'h0}; // R09
	wire logic [7:0] reg_view = {6'h00, reg_mask_reg, lif.q[IFL_ROW_REG][IFL_REG_FLAG_BIT]}; // R07
	wire logic [7:0] rdata_next =
		sel_ch1 ? lif.q[IFL_ROW_CH1] : // R02
		sel_ch2 ? lif.q[IFL_ROW_CH2] : // R06
		sel_ovld ? ovld_view :
		sel_reg ? reg_view :
		sel_ovhs ? lif.q[IFL_ROW_OVHS] : // R11
		sel_tvb ? lif.q[IFL_ROW_TVB] : // R14
		IFL_RESET_VAL;

	// read data register, valid one cycle after the strobe
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			REG_RDATA_OUT <= IFL_RESET_VAL; // R16
			REG_RVALID_OUT <= 1'b0;
		end
		else
		begin
			REG_RVALID_OUT <= REG_RD_IN;
			if (REG_RD_IN)
			begin
				REG_RDATA_OUT <= rdata_next; // R03
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt: any unmasked latched flag or overload
	wire logic [7:0] ch1_live = lif.q[IFL_ROW_CH1] & ~CH1_MASK_IN; // R17
	wire logic [7:0] ch2_live = lif.q[IFL_ROW_CH2] & ~CH2_MASK_IN; // R17
	wire logic [7:0] ovhs_live = lif.q[IFL_ROW_OVHS] & ~OVHS_MASK_IN; // R12
	wire logic [7:0] tvb_live = lif.q[IFL_ROW_TVB] & ~TVB_MASK_IN; // R15
	wire logic reg_live = lif.q[IFL_ROW_REG][IFL_REG_FLAG_BIT] & ~reg_mask_reg; // R17
	wire logic ovld_live = (CONVERTER_OVERLOAD_IN[1] & ~ovld_ch1_mask_reg)
		| (CONVERTER_OVERLOAD_IN[0] & ~ovld_ch2_mask_reg); // R17
	wire logic irq_next = (|ch1_live) | (|ch2_live) | (|ovhs_live) | (|tvb_live)
		| reg_live | ovld_live;

	// interrupt register
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			IRQ_OUT <= 1'b0;
		end
		else
		begin
			IRQ_OUT <= irq_next; // R17
		end
	end

	////////////////////////////////////////////////////////////////
	// channel summary: set by any fault, cleared by reading that channel
	logic sum_ch1_reg; // channel 1 summary
	logic sum_ch2_reg; // channel 2 summary
	wire logic sum_ch1_next = (sum_ch1_reg & ~lif.rd_clr[IFL_ROW_CH1]) | (|CH1_FAULT_IN); // R18
	wire logic sum_ch2_next = (sum_ch2_reg & ~lif.rd_clr[IFL_ROW_CH2]) | (|CH2_FAULT_IN); // R18

	// summary state
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			sum_ch1_reg <= 1'b0;
			sum_ch2_reg <= 1'b0;
		end
		else
		begin
			sum_ch1_reg <= sum_ch1_next;
			sum_ch2_reg <= sum_ch2_next;
		end
	end

	// summary output register, reserved positions zero
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			CHANNEL_SUMMARY_OUT <= IFL_RESET_VAL;
		end
		else
		begin
			CHANNEL_SUMMARY_OUT <= {sum_ch1_next, sum_ch2_next, 6'h00}; // R18
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RST_B_IN);

	// open channel 1 inputs appear in bit 7 on the next read
	ch1_open_a: assert property (CH1_FAULT_IN[IFL_OPEN_BIT] ##1 (REG_RD_IN && sel_ch1) // R01
		|=> REG_RDATA_OUT[IFL_OPEN_BIT])
		else $error("channel 1 open flag lost");

	// ground short of the negative pin lands in bit 4
	ch1_ground_a: assert property (CH1_FAULT_IN[IFL_NEG_GND_BIT] // R02
		|=> lif.q[IFL_ROW_CH1][IFL_NEG_GND_BIT])
		else $error("channel 1 ground flag not latched");

	// bias short of the positive pin lands in bit 3
	ch1_bias_a: assert property (CH1_FAULT_IN[IFL_POS_BIAS_BIT] // R03
		|=> lif.q[IFL_ROW_CH1][IFL_POS_BIAS_BIT])
		else $error("channel 1 bias flag not latched");

	// channel 2 read returns the channel 2 latch
	ch2_read_a: assert property ((REG_RD_IN && sel_ch2) // R05
		|=> REG_RDATA_OUT == $past(lif.q[IFL_ROW_CH2]))
		else $error("channel 2 read data wrong");

	// regulator read shows mask in bit 1 and flag in bit 0
	reg_read_a: assert property ((REG_RD_IN && sel_reg) // R07
		|=> REG_RDATA_OUT == {6'h00, $past(reg_mask_reg), $past(lif.q[IFL_ROW_REG][IFL_REG_FLAG_BIT])})
		else $error("regulator read data wrong");

	// overload mask write lands in bits 3 and 2
	ovld_write_a: assert property (wr_ovld // R08
		|=> {ovld_ch1_mask_reg, ovld_ch2_mask_reg} == $past(REG_WDATA_IN[3:2]))
		else $error("overload mask write wrong");

	// reserved bits of the overload mask read zero
	reserved_zero_a: assert property ((REG_RD_IN && sel_ovld) // R09
		|=> REG_RDATA_OUT[7:4] == 4'h0 && REG_RDATA_OUT[1:0] == 2'h0)
		else $error("reserved bits read non zero");

	// overvoltage of the last pin lands in bit 4 of event latch one
	ovv_latch_a: assert property (OVERVOLT_HEADSET_IN[IFL_OV_CH2N_BIT] // R10
		|=> lif.q[IFL_ROW_OVHS][IFL_OV_CH2N_BIT])
		else $error("overvoltage flag not latched");

	// bias overvoltage stays until read
	bias_hold_a: assert property (lif.q[IFL_ROW_TVB][IFL_BIAS_OV_BIT] && !(REG_RD_IN && sel_tvb) // R15
		|=> lif.q[IFL_ROW_TVB][IFL_BIAS_OV_BIT])
		else $error("bias flag dropped without read");

	// read with no new condition clears the row
	clear_read_a: assert property ((REG_RD_IN && sel_ovhs && OVERVOLT_HEADSET_IN == 8'h00) // R19
		|=> lif.q[IFL_ROW_OVHS] == 8'h00)
		else $error("read did not clear flags");

	// writes never touch the channel 1 latched row
	ro_write_a: assert property ((REG_WR_IN && sel_ch1 && !REG_RD_IN && CH1_FAULT_IN == 8'h00) // R20
		|=> lif.q[IFL_ROW_CH1] == $past(lif.q[IFL_ROW_CH1]))
		else $error("write changed a latched flag");

	// everything fully masked keeps the interrupt low
	irq_mask_a: assert property ((!(|(ch1_live | ch2_live | ovhs_live | tvb_live)) && !reg_live && !ovld_live) // R17
		|=> !IRQ_OUT)
		else $error("masked source raised interrupt");

	// channel summary follows any channel 2 fault
	summary_a: assert property ((|CH2_FAULT_IN) |=> CHANNEL_SUMMARY_OUT[IFL_SUM_CH2_BIT]) // R18
		else $error("channel 2 summary missed");

	// channel summary follows any channel 1 fault
	summary_ch1_a: assert property ((|CH1_FAULT_IN) |=> CHANNEL_SUMMARY_OUT[IFL_SUM_CH1_BIT]) // R18
		else $error("channel 1 summary missed");

	// shorted channel 1 inputs land in bit 6
	ch1_shorted_a: assert property (CH1_FAULT_IN[IFL_SHORTED_BIT] // R01
		|=> lif.q[IFL_ROW_CH1][IFL_SHORTED_BIT])
		else $error("channel 1 shorted flag not latched");

	// battery short of the negative pin lands in bit 0
	ch1_batt_a: assert property (CH1_FAULT_IN[IFL_NEG_BATT_BIT] // R04
		|=> lif.q[IFL_ROW_CH1][IFL_NEG_BATT_BIT])
		else $error("channel 1 battery flag not latched");

	// battery short of the positive pin lands in bit 1
	ch1_batt_pos_a: assert property (CH1_FAULT_IN[IFL_POS_BATT_BIT] // R04
		|=> lif.q[IFL_ROW_CH1][IFL_POS_BATT_BIT])
		else $error("channel 1 positive battery flag not latched");

	// every channel 2 raw fault shows in its own bit
	ch2_fields_a: assert property ((|CH2_FAULT_IN) // R06
		|=> (lif.q[IFL_ROW_CH2] & $past(CH2_FAULT_IN)) == $past(CH2_FAULT_IN))
		else $error("channel 2 fault bit not latched");

	// headset insertion lands in bit 3 of event latch one
	hs_insert_a: assert property (OVERVOLT_HEADSET_IN[IFL_HS_INSERT_BIT] // R11
		|=> lif.q[IFL_ROW_OVHS][IFL_HS_INSERT_BIT])
		else $error("headset insert flag not latched");

	// processing capacity overload lands in bit 0
	capacity_a: assert property (OVERVOLT_HEADSET_IN[IFL_CAPACITY_BIT] // R12
		|=> lif.q[IFL_ROW_OVHS][IFL_CAPACITY_BIT])
		else $error("capacity flag not latched");

	// upper threshold crossing lands in bit 7 of event latch two
	thr_up_a: assert property (THRESH_VOICE_BIAS_IN[IFL_THR_UP_BIT] // R13
		|=> lif.q[IFL_ROW_TVB][IFL_THR_UP_BIT])
		else $error("threshold flag not latched");

	// voice activity power-down lands in bit 4
	vad_down_a: assert property (THRESH_VOICE_BIAS_IN[IFL_VAD_DOWN_BIT] // R14
		|=> lif.q[IFL_ROW_TVB][IFL_VAD_DOWN_BIT])
		else $error("voice activity flag not latched");

	// writes never touch the channel 2 row either
	ch2_write_a: assert property ((REG_WR_IN && sel_ch2 && !REG_RD_IN && CH2_FAULT_IN == 8'h00) // R20
		|=> lif.q[IFL_ROW_CH2] == $past(lif.q[IFL_ROW_CH2]))
		else $error("write changed a channel 2 flag");

	// reset leaves read data, read valid and interrupt at zero
	reset_zero_a: assert property (@(posedge CLOCK_IN) disable iff (1'b0) // R16
		!RST_B_IN |=> (REG_RDATA_OUT == IFL_RESET_VAL) && !IRQ_OUT && !REG_RVALID_OUT)
		else $error("outputs not cleared by reset");

	// main scenarios
	fault_read_c: cover property (CH1_FAULT_IN[IFL_OPEN_BIT] ##1 (REG_RD_IN && sel_ch1));
	irq_raise_c: cover property (!IRQ_OUT ##1 IRQ_OUT);
	mask_write_c: cover property (wr_reg && REG_WDATA_IN[IFL_REG_MASK_BIT]);
	set_clear_c: cover property (REG_RD_IN && sel_tvb && (|THRESH_VOICE_BIAS_IN));
	overload_irq_c: cover property (ovld_live ##1 IRQ_OUT);
endmodule : ifl_status_top
`default_nettype wire

// ==== sim/ifl_detect_model.sv ====
// raw condition source standing in for the analogue detectors
`timescale 1ns/1ps
`default_nettype none
module ifl_detect_model
(
	// request from the bench
	input wire logic [2:0] sel_in,
	input wire logic [7:0] pat_in,
	input wire logic fire_in,
	// raw condition rows, high = condition present
	output logic [7:0] ch1_out,
	output logic [7:0] ch2_out,
	output logic reg_short_out,
	output logic [7:0] ovhs_out,
	output logic [7:0] tvb_out
);
	////////////////////////////////////////////////////////////////
	// detectors report a level only while a condition is present
	assign ch1_out = (fire_in && sel_in == 3'h0) ? pat_in : 8'h00;
	assign ch2_out = (fire_in && sel_in == 3'h1) ? pat_in : 8'h00;
	assign reg_short_out = fire_in && sel_in == 3'h2 && pat_in[0];
	assign ovhs_out = (fire_in && sel_in == 3'h3) ? pat_in : 8'h00;
	assign tvb_out = (fire_in && sel_in == 3'h4) ? pat_in : 8'h00;
endmodule : ifl_detect_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the latched status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ifl_pkg::*;
	// clock, reset and register port
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic rvalid;
	// detector requests and masks
	logic [2:0] sel = 3'h0;
	logic [7:0] pat = 8'h00;
	logic fire = 1'b0;
	logic [7:0] ch1m = 8'hff;
	logic [7:0] ch2m = 8'hff;
	logic [7:0] ovm = 8'hff;
	logic [7:0] tvm = 8'hff;
	logic [1:0] ovld = 2'h0;
	// design outputs and raw rows
	logic irq;
	logic [7:0] summ;
	logic [7:0] raw1, raw2, rawo, rawt;
	logic rawr;
	// bookkeeping
	int fails = 0;
	int checked = 0;
	int seed = 32'h3c61;
	logic [7:0] p;
	logic [7:0] radr [5] = '{IFL_CH1_FAULT_ADDR, IFL_CH2_FAULT_ADDR, IFL_REG_SHORT_ADDR, IFL_OVHS_ADDR, IFL_TVB_ADDR};

	always #4 clk = ~clk;

	ifl_detect_model i_det (.sel_in(sel), .pat_in(pat), .fire_in(fire), .ch1_out(raw1), .ch2_out(raw2),
		.reg_short_out(rawr), .ovhs_out(rawo), .tvb_out(rawt));

	ifl_status_top i_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .CH1_FAULT_IN(raw1),
		.CH2_FAULT_IN(raw2), .REGULATOR_SHORT_IN(rawr), .OVERVOLT_HEADSET_IN(rawo), .THRESH_VOICE_BIAS_IN(rawt),
		.CONVERTER_OVERLOAD_IN(ovld), .CH1_MASK_IN(ch1m), .CH2_MASK_IN(ch2m), .OVHS_MASK_IN(ovm),
		.TVB_MASK_IN(tvm), .IRQ_OUT(irq), .CHANNEL_SUMMARY_OUT(summ));

	////////////////////////////////////////////////////////////////
	// reference model: latched rows, writable masks, last read value
	int mdl [5] = '{default: 0};
	int mmask [2] = '{default: 0};
	int mrd = 0;

	// raw row as the rules place it
	function automatic int raw_row(input int i);
		case (i)
			0: raw_row = raw1;
			1: raw_row = raw2;
			2: raw_row = rawr;
			3: raw_row = rawo;
			default: raw_row = rawt;
		endcase
	endfunction : raw_row

	// value a read of this address returns
	function automatic int model_read(input logic [7:0] a);
		model_read = (a == IFL_OVLD_MASK_ADDR) ? mmask[0] : 0;
		for (int i = 0; i < 5; i++)
			if (a == radr[i])
				model_read = mdl[i] | ((i == 2) ? mmask[1] : 0);
	endfunction : model_read

	// model update on every edge, raw sets, a read clears
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			mdl <= '{default: 0};
			mmask <= '{default: 0};
		end
		else
		begin
			if (rd)
				mrd <= model_read(addr);
			for (int i = 0; i < 5; i++)
				mdl[i] <= ((rd && addr == radr[i]) ? 0 : mdl[i]) | raw_row(i);
			if (wr && addr == IFL_OVLD_MASK_ADDR)
				mmask[0] <= wdata & 8'h0c;
			if (wr && addr == IFL_REG_SHORT_ADDR)
				mmask[1] <= wdata & 8'h02;
		end
	end

	////////////////////////////////////////////////////////////////
	// compare one value, report at once
	task check(input logic [7:0] got, input logic [7:0] want);
		checked++;
		if (got !== want)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : check

	// one read, answer one cycle later
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1 rd = 1'b0;
		check({7'h00, rvalid}, 8'h01);
		check(rdata, e);
		check(rdata, 8'(mrd));
	endtask : rd_chk

	// one write, no answer
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask : wr_reg

	// raw condition present for one cycle
	task pulse(input logic [2:0] r, input logic [7:0] d);
		@(posedge clk);
		#1 sel = r;
		pat = d;
		fire = 1'b1;
		@(posedge clk);
		#1 fire = 1'b0;
	endtask : pulse

	// interrupt level after two edges
	task irq_chk(input logic e);
		repeat (2) @(posedge clk);
		#1 check({7'h00, irq}, {7'h00, e});
	endtask : irq_chk

	// one unmasked raw bit raises the interrupt until its row is read
	task irq_row(input int r, input logic [7:0] d);
		pulse(3'(r), d);
		irq_chk(1'b1);
		rd_chk(radr[r], d);
		irq_chk(1'b0);
	endtask : irq_row

	// every register and the unmapped place read zero
	task reset_chk;
		for (int i = 0; i < 5; i++)
			rd_chk(radr[i], IFL_RESET_VAL);
		rd_chk(IFL_OVLD_MASK_ADDR, IFL_RESET_VAL);
		rd_chk(8'h40, 8'h00);
		check(summ, 8'h00);
		$display("test reset values done");
	endtask : reset_chk

	// verdict and end of run
	task results;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////
	// hang guard
	initial
	begin
		#400000;
		fails++;
		results();
	end

	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		#1 rst_b = 1'b1;
		reset_chk();
		// every bit of every row, then a random pattern
		for (int r = 0; r < 5; r++)
			for (int b = 0; b < 9; b++)
			begin
				p = (b < 8) ? 8'h01 << b : 8'($random(seed));
				if (r == 2)
					p = p & 8'h01;
				pulse(3'(r), p);
				if (r < 2)
					check(summ, (p != 8'h00) ? 8'h80 >> r : 8'h00);
				rd_chk(radr[r], p);
				rd_chk(radr[r], 8'h00);
			end
		$display("test latch layout done");
		// condition persisting across reads
		p = 8'($random(seed));
		@(posedge clk);
		#1 sel = 3'h3;
		pat = p;
		fire = 1'b1;
		rd_chk(IFL_OVHS_ADDR, p);
		rd_chk(IFL_OVHS_ADDR, p);
		fire = 1'b0;
		rd_chk(IFL_OVHS_ADDR, p);
		rd_chk(IFL_OVHS_ADDR, 8'h00);
		$display("test persisting condition done");
		// mask registers and ignored writes
		wr_reg(IFL_OVLD_MASK_ADDR, 8'h0c);
		rd_chk(IFL_OVLD_MASK_ADDR, 8'h0c);
		wr_reg(IFL_REG_SHORT_ADDR, 8'h02);
		pulse(3'h2, 8'h01);
		rd_chk(IFL_REG_SHORT_ADDR, 8'h03);
		rd_chk(IFL_REG_SHORT_ADDR, 8'h02);
		wr_reg(IFL_CH1_FAULT_ADDR, 8'($random(seed)));
		rd_chk(IFL_CH1_FAULT_ADDR, 8'h00);
		wr_reg(IFL_CH2_FAULT_ADDR, 8'hff);
		rd_chk(IFL_CH2_FAULT_ADDR, 8'h00);
		wr_reg(8'h40, 8'hff);
		rd_chk(8'h40, 8'h00);
		$display("test masks and writes done");
		// interrupt output against masks
		pulse(3'h3, 8'h80);
		irq_chk(1'b0);
		ovm = 8'h00;
		irq_chk(1'b1);
		rd_chk(IFL_OVHS_ADDR, 8'h80);
		irq_chk(1'b0);
		ovld = 2'h2;
		irq_chk(1'b0);
		wr_reg(IFL_OVLD_MASK_ADDR, 8'h04);
		irq_chk(1'b1);
		ovld = 2'h1;
		irq_chk(1'b0);
		ovld = 2'h0;
		// channel and event rows, one open bit each
		ch1m = 8'hbf;
		ch2m = 8'hfb;
		tvm = 8'hfe;
		irq_row(0, 8'h40);
		irq_row(1, 8'h04);
		irq_row(4, 8'h01);
		ch1m = 8'hff;
		ch2m = 8'hff;
		tvm = 8'hff;
		$display("test interrupt masks done");
		// reset in mid-run clears everything
		pulse(3'h0, 8'hff);
		@(posedge clk);
		#1 rst_b = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		reset_chk();
		results();
	end
endmodule : tb_top
`default_nettype wire
